/* hdl/lcdcd_column_driver.sv */
// Column driver top: host draw port, bitmap memory, line refresh and drive
`timescale 1ns/100ps
module lcdcd_column_driver
  import lcdcd_pkg::*;
(
  input  wire logic                       sys_clk,
  input  wire logic                       reset,
  input  wire logic                       line_transfer_clock,
  input  wire logic                       first_line_marker,
  input  wire logic                       acPolarity,
  input  wire logic                       display_blank_n,
  input  wire logic                       output_order_reverse,
  input  wire logic                       id_strap_bit0,
  input  wire logic                       id_strap_bit1,
  input  wire logic                       testMode,
  input  wire logic                       chipSelect_n,
  input  wire logic                       writeStrobe_n,
  input  wire logic                       readStrobe_n,
  input  wire logic [lcdcd_pkg::ADDR_W-1:0] host_address,
  input  wire logic [7:0]                 hostDataIn,
  output logic      [7:0]                 hostDataOut,
  output logic                            hostDataOe_n,
  output logic                            drawBusy,
  output logic      [2*lcdcd_pkg::COLUMNS-1:0] column_drive_outputs,
  output logic      [lcdcd_pkg::FRC_W-1:0] frameRateGrayPhase
);
  import lcdcd_pkg::*;

  // Three-stage synchronisers for host strobes (pins outside the clock)
  logic [2:0] csSync_q;   // Chip select sampler
  logic [2:0] weSync_q;   // Write strobe sampler
  logic [2:0] oeSync_q;   // Read strobe sampler
  logic       csAct_q;    // Filtered chip select, active high
  logic       weAct_q;    // Filtered write strobe, active high
  logic       oeAct_q;    // Filtered read strobe, active high
  logic       weAct_d;    // Write strobe start pulse
  logic       oeAct_d;    // Read strobe start pulse
  logic [1:0] idVal_q;    // Strap value caught after reset
  logic       revVal_q;   // Order reverse caught after reset

  // Memory, refresh and drive state
  logic [7:0]             ram [MEM_DEPTH];          // Display bitmap memory
  logic [LINE_CNT_W-1:0]  refLine_q;                // Line being refreshed, held until the next transfer
  logic [COL_IDX_W-1:0]   refCol_q;                 // Byte being refreshed
  lcdcd_ref_t             refState_q;               // Refresh machine state
  logic [2*COLUMNS-1:0]   lineBuf_q;                // First latch, raw pixels
  logic [2*COLUMNS-1:0]   driveLat_q;               // Second latch, loaded when refresh ends
  logic [FRC_W-1:0]       frc_q;                    // Frame counter for gray
  logic [7:0]             rdData_q;                 // Last read byte
  logic                   rdPend_q;                 // Read result awaited

  // Host decode
  logic                   inWindow;                 // Address inside own space
  logic [MEM_AW-1:0]      hostMemAddr;              // Translated address
  lcdcd_cmd_t             cmdIn;                    // Command to FIFO
  lcdcd_cmd_t             cmdOut;                   // Command from FIFO
  logic                   cmdInValid;               // Push request
  logic                   cmdInReady;               // FIFO has room
  logic                   cmdOutValid;              // Command pending
  logic                   cmdOutReady;              // Memory port free for draw
  logic                   refReq;                   // Refresh wants memory

  // Link domain crossing of transfer edges
  logic                   linkTog_q;                // Toggles on each rising link edge
  logic                   linkFlm_q;                // Marker sampled on link edge
  logic                   linkRst_q;                // Reset copy that clears the link flops
  logic [2:0]             togSync_q;                // Toggle synchroniser
  logic [2:0]             flmSync_q;                // Marker synchroniser
  logic                   lineEvent;                // One pulse per transfer
  logic                   lineFirst;                // Transfer starts a frame

  // Function: memory address from line and byte index
  function automatic logic [MEM_AW-1:0] memIndex(input logic [LINE_CNT_W-1:0] ln,
                                                 input logic [COL_IDX_W-1:0] cb);
    logic [MEM_AW-1:0] base;
    base = MEM_AW'(ln) * MEM_AW'(BYTES_LINE);
    memIndex = base + MEM_AW'(cb);
  endfunction

  // Function: drive level from polarity and a two-bit gray pixel
  function automatic logic [1:0] levelOf(input logic pol, input logic [1:0] px,
                                         input logic [FRC_W-1:0] ph);
    logic on;
    on = (px == 2'h3) || (px == 2'h2 && ph != 2'h0) || (px == 2'h1 && ph == 2'h0);
    if (on) begin
      levelOf = pol ? LEVEL_V2 : LEVEL_V1;
    end else begin
      levelOf = pol ? LEVEL_V4 : LEVEL_V3;
    end
  endfunction

  // Strap capture, clocked after release so reset holds only constants
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      idVal_q  <= 2'h0;
      revVal_q <= 1'b0;
    end else begin
      idVal_q  <= {id_strap_bit1, id_strap_bit0};
      revVal_q <= output_order_reverse;
    end
  end

  // Strobe synchronisers, three stages
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      csSync_q <= 3'h0;
      weSync_q <= 3'h0;
      oeSync_q <= 3'h0;
    end else begin
      csSync_q <= {csSync_q[1:0], !chipSelect_n};
      weSync_q <= {weSync_q[1:0], !writeStrobe_n};
      oeSync_q <= {oeSync_q[1:0], !readStrobe_n};
    end
  end

  // Filtered levels change only when stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      csAct_q <= 1'b0;
      weAct_q <= 1'b0;
      oeAct_q <= 1'b0;
    end else begin
      if (csSync_q[1] == csSync_q[2]) begin
        csAct_q <= csSync_q[2];
      end
      if (weSync_q[1] == weSync_q[2]) begin
        weAct_q <= weSync_q[2];
      end
      if (oeSync_q[1] == oeSync_q[2]) begin
        oeAct_q <= oeSync_q[2];
      end
    end
  end

  // Address window and translation
  always_comb begin
    // fixed partition: ID selects a quarter of line space
    // window match needs identity in address top bits
    inWindow = (host_address[LINE_MSB:LINE_MSB-1] == idVal_q)
               && (host_address[LINE_MSB-2:LINE_LSB] < 7'(LINES / 2))
               && (host_address[COL_MSB:0] < 7'(BYTES_LINE));
    // upper bits line, lower bits byte
    // translated so host map ignores panel side
    hostMemAddr = memIndex(LINE_CNT_W'(host_address[LINE_MSB-2:LINE_LSB]),
                           COL_IDX_W'(host_address[COL_MSB:0]));
  end

  // Strobe edges: the address is held steady by the host through the strobe
  // Select comes from its own agreeing stages, so one falling with the strobe is not missed
  assign weAct_d = csSync_q[2] && csSync_q[1] && weSync_q[2] && weSync_q[1] && !weAct_q;
  assign oeAct_d = csSync_q[2] && csSync_q[1] && oeSync_q[2] && oeSync_q[1] && !oeAct_q;

  // write or read queued on strobe start inside window, unless in test mode
  assign cmdInValid    = (weAct_d || oeAct_d) && inWindow && !testMode;
  assign cmdIn.isWrite = weAct_d;
  assign cmdIn.addr    = hostMemAddr;
  assign cmdIn.data    = hostDataIn;
  assign drawBusy      = !cmdInReady || rdPend_q;

  lcdcd_fifo #(
    .WIDTH ($bits(lcdcd_cmd_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_cmd_fifo (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .inValid  (cmdInValid),
    .inReady  (cmdInReady),
    .inData   (cmdIn),
    .outValid (cmdOutValid),
    .outReady (cmdOutReady),
    .outData  (cmdOut)
  );

  // refresh has priority; draw stalls meanwhile
  assign refReq      = (refState_q == REF_READ);
  assign cmdOutReady = !refReq;

  // Memory write port for draw
  always_ff @(posedge sys_clk) begin
    if (cmdOutValid && cmdOutReady && cmdOut.isWrite) begin
      ram[cmdOut.addr] <= cmdOut.data;
    end
  end

  // Draw read result and pin drive
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdData_q <= 8'h00;
      rdPend_q <= 1'b0;
    end else begin
      if (cmdInValid && !cmdIn.isWrite) begin
        rdPend_q <= 1'b1;
      end else if (cmdOutValid && cmdOutReady && !cmdOut.isWrite) begin
        rdData_q <= ram[cmdOut.addr];
        rdPend_q <= 1'b0;
      end
    end
  end

  // byte of four packed pixels on data pins
  assign hostDataOut  = rdData_q;
  assign hostDataOe_n = !(csAct_q && oeAct_q && inWindow && !rdPend_q);

  // Reset copy for the link side; its first edge clears the link flops before any transfer
  always_ff @(posedge sys_clk) begin
    linkRst_q <= reset;
  end

  // Link side: one toggle and marker sample per rising transfer edge
  // Cleared asynchronously, as the link clock stands still while reset is held
  always_ff @(posedge line_transfer_clock or posedge linkRst_q) begin
    if (linkRst_q) begin
      linkTog_q <= 1'b0;
      linkFlm_q <= 1'b0;
    end else begin
      linkTog_q <= !linkTog_q;
      linkFlm_q <= first_line_marker;
    end
  end

  // Cross the toggle and marker into the system clock
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      togSync_q <= 3'h0;
      flmSync_q <= 3'h0;
    end else begin
      togSync_q <= {togSync_q[1:0], linkTog_q};
      flmSync_q <= {flmSync_q[1:0], linkFlm_q};
    end
  end
  assign lineEvent = togSync_q[2] != togSync_q[1];
  // Marker stage level with the toggle's second stage, so it belongs to this transfer
  assign lineFirst = flmSync_q[1];

  // Line counter and refresh sequencer
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      refLine_q  <= '0;
      refCol_q   <= '0;
      refState_q <= REF_IDLE;
    end else begin
      case (refState_q)
        REF_IDLE: begin
          if (lineEvent) begin
            // marker restarts frame at line zero
            if (lineFirst) begin
              refLine_q <= '0;
            end else if (refLine_q == LINE_CNT_W'(LINES - 1)) begin
              refLine_q <= '0;
            end else begin
              refLine_q <= refLine_q + 1'b1;
            end
            refCol_q   <= '0;
            refState_q <= REF_READ;
          end
        end
        REF_READ: begin
          if (refCol_q == COL_IDX_W'(BYTES_LINE - 1)) begin
            refState_q <= REF_DONE;
          end else begin
            refCol_q <= refCol_q + 1'b1;
          end
        end
        REF_DONE: begin
          refState_q <= REF_IDLE;
        end
        default: begin
          refState_q <= REF_IDLE;
        end
      endcase
    end
  end

  // Refresh reads fill the first latch a byte at a time
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      lineBuf_q <= '0;
    end else if (refState_q == REF_READ) begin
      // adjacent bit pairs, pixel 0 lowest
      lineBuf_q[8*refCol_q +: 8] <= ram[memIndex(refLine_q, refCol_q)];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      frc_q <= '0;
    end else if (lineEvent && lineFirst) begin
      frc_q <= frc_q + 1'b1;
    end
  end
  assign frameRateGrayPhase = frc_q;

  // line passed to drive stage when its refresh completes
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      driveLat_q <= '0;
    end else if (refState_q == REF_DONE) begin
      driveLat_q <= lineBuf_q;
    end
  end

  // Drive level per column
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      column_drive_outputs <= '0;
    end else begin
      for (int c = 0; c < COLUMNS; c++) begin
        if (!display_blank_n) begin
          column_drive_outputs[2*c +: 2] <= LEVEL_V1;
        // reversed order maps last pixel first
        end else if (revVal_q) begin
          column_drive_outputs[2*c +: 2] <=
            levelOf(acPolarity, driveLat_q[2*(COLUMNS-1-c) +: 2], frc_q);
        end else begin
          column_drive_outputs[2*c +: 2] <= levelOf(acPolarity, driveLat_q[2*c +: 2], frc_q);
        end
      end
    end
  end

  a_blank_forces_v1 : assert property (@(posedge sys_clk) disable iff (reset)
    !display_blank_n |=> (column_drive_outputs[1:0] == LEVEL_V1))
    else $error("Blanking did not force select-high");
  a_marker_line_zero : assert property (@(posedge sys_clk) disable iff (reset)
    (refState_q == REF_IDLE && lineEvent && lineFirst) |=> (refLine_q == '0))
    else $error("Marker did not clear line counter");
  a_line_increments : assert property (@(posedge sys_clk) disable iff (reset)
    (refState_q == REF_IDLE && lineEvent && !lineFirst && refLine_q < 8'hEF)
    |=> (refLine_q == $past(refLine_q) + 8'h01))
    else $error("Line counter did not step");
  a_transfer_bounded : assert property (@(posedge sys_clk) disable iff (reset)
    (refState_q == REF_IDLE && lineEvent) |=> ##[1:45] (refState_q == REF_DONE))
    else $error("Line latch not reached in time");
  a_refresh_priority : assert property (@(posedge sys_clk) disable iff (reset)
    (refState_q == REF_READ) |-> !cmdOutReady)
    else $error("Draw served during refresh read");
  a_window_gate : assert property (@(posedge sys_clk) disable iff (reset)
    !inWindow |-> !cmdInValid)
    else $error("Access accepted outside window");
  // pins driven only with chip select
  a_read_drive : assert property (@(posedge sys_clk) disable iff (reset)
    !hostDataOe_n |-> (csAct_q && oeAct_q))
    else $error("Data pins driven without read");
  // gray phase advances per frame only
  a_frc_step : assert property (@(posedge sys_clk) disable iff (reset)
    !(lineEvent && lineFirst) |=> (frc_q == $past(frc_q)))
    else $error("Gray phase moved mid-frame");

  c_write_queued : cover property (@(posedge sys_clk) cmdInValid && cmdIn.isWrite);
  c_read_served  : cover property (@(posedge sys_clk) $fell(rdPend_q));
  c_frame_start  : cover property (@(posedge sys_clk) lineEvent && lineFirst);
  c_draw_stalled : cover property (@(posedge sys_clk) cmdOutValid && refReq);
endmodule

/* inc/lcdcd_pkg.sv */
// Package of constants and carrier types for the column driver with bitmap RAM
// Overview of operation
// - Hold 160x240x2 memory, drive 160 columns
// - Upper nine address bits select line
// - Two ID straps give identity zero to three
// - Accept only own window while selected
// - Write strobe stores data in window
// - Read strobe drives stored data out
// - Data byte packs four two-bit pixels
// - Reverse input flips column output order
// - First-line marker clears line counter
// - Transfer clock rising edge latches line
// - Polarity and pixel pick drive level
// - Blanking low forces select-high level
// - Refresh and draw accesses arbitrated internally
// - Host addresses translated to internal map
// - Timing drives frame-rate gray sequencing
// - Line counter increments per transfer clock
// - Pixel bit pairs sit adjacent
package lcdcd_pkg;
  localparam int COLUMNS      = 160;                 // Column outputs
  localparam int LINES        = 240;                 // Lines in memory
  localparam int BYTES_LINE   = COLUMNS / 4;         // Four pixels a byte
  localparam int ADDR_W       = 16;                  // Host address width
  localparam int LINE_MSB     = 15;                  // Line field top bit
  localparam int LINE_LSB     = 7;                   // Line field low bit
  localparam int COL_MSB      = 6;                   // Byte field top bit
  localparam int LINE_CNT_W   = 8;                   // Internal line index
  localparam int COL_IDX_W    = 6;                   // Internal byte index
  localparam int MEM_DEPTH    = LINES * BYTES_LINE;  // Bytes in memory
  localparam int MEM_AW       = 14;                  // Memory address width
  localparam int FIFO_DEPTH   = 16;                  // Draw command FIFO depth
  localparam int FRC_W        = 2;                   // Gray phase counter width
  localparam logic [1:0] LEVEL_V1 = 2'h0;            // Select high level
  localparam logic [1:0] LEVEL_V2 = 2'h1;            // Select low level
  localparam logic [1:0] LEVEL_V3 = 2'h2;            // Deselect high level
  localparam logic [1:0] LEVEL_V4 = 2'h3;            // Deselect low level

  // Draw command travelling from the host port to the memory side
  typedef struct packed {
    logic                  isWrite;  // Write when set, read otherwise
    logic [MEM_AW-1:0]     addr;     // Internal memory address
    logic [7:0]            data;     // Write data
  } lcdcd_cmd_t;

  // Display refresh state
  typedef enum logic [1:0] {REF_IDLE, REF_READ, REF_DONE} lcdcd_ref_t;
endpackage

/* hdl/lcdcd_fifo.sv */
// Parameterised valid/ready FIFO for draw commands
`timescale 1ns/100ps
module lcdcd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];  // Storage array
  logic [PW:0]      wrPtr_q;      // Write pointer with wrap bit
  logic [PW:0]      rdPtr_q;      // Read pointer with wrap bit
  logic             push;         // Accepted word
  logic             pop;          // Delivered word

  // Full when pointers differ only in the wrap bit
  assign inReady  = !((wrPtr_q[PW] != rdPtr_q[PW]) && (wrPtr_q[PW-1:0] == rdPtr_q[PW-1:0]));
  assign outValid = (wrPtr_q != rdPtr_q);
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem[rdPtr_q[PW-1:0]];

  // Storage write
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wrPtr_q[PW-1:0]] <= inData;
    end
  end

  // Pointers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
    end
  end

  a_fifo_no_overflow : assert property (@(posedge sys_clk) disable iff (reset)
    !inReady |-> ##1 (wrPtr_q == $past(wrPtr_q)))
    else $error("FIFO pointer moved while full");
endmodule

/* bench/lcdcd_lcd_timer.sv */
// Behavioural LCD timing controller issuing line transfer pulses
`timescale 1ns/100ps
module lcdcd_lcd_timer (
  output logic line_transfer_clock,
  output logic first_line_marker
);
  // Link clock rests low between transfers, marker idles low
  initial begin
    line_transfer_clock = 1'b0;
    first_line_marker   = 1'b0;
  end

  // One 6 ns high link pulse; marker set up before and held after the rising edge
  // frame start marker
  task automatic line_pulse(input logic mk);
    first_line_marker = mk;
    #20 line_transfer_clock = 1'b1;
    #6 line_transfer_clock = 1'b0;
    #20 first_line_marker = 1'b0;
    // Gap keeps the transfer period above the refresh time of the device
    #5100;
  endtask
endmodule

/* bench/lcdcd_column_driver_tb.sv */
// Self-checking bench for the column driver with bitmap RAM
`timescale 1ns/100ps
module lcdcd_column_driver_tb;
  import lcdcd_pkg::*;
  localparam logic [1:0] MY_ID = 2'h2;              // Strapped identity
  logic                   sys_clk              = 1'b0;
  logic                   reset                = 1'b1;
  logic                   acPolarity           = 1'b0;
  logic                   display_blank_n      = 1'b1;
  logic                   output_order_reverse = 1'b0;
  logic                   testMode             = 1'b0;
  logic                   chipSelect_n         = 1'b1;
  logic                   writeStrobe_n        = 1'b1;
  logic                   readStrobe_n         = 1'b1;
  logic [ADDR_W-1:0]      host_address         = 16'h0000;
  logic [7:0]             busDrv               = 8'hFF;  // Host side of data pins
  logic [7:0]             hostDataIn;
  logic [7:0]             hostDataOut;
  logic                   hostDataOe_n;
  logic                   drawBusy;
  logic [2*COLUMNS-1:0]   column_drive_outputs;
  logic [FRC_W-1:0]       frameRateGrayPhase;
  logic                   line_transfer_clock;
  logic                   first_line_marker;
  logic [7:0]             shadow [0:MEM_DEPTH-1];      // Expected memory image
  int                     n_errors  = 0;
  int                     tests_run = 0;

  // 10 MHz system clock
  always #50 sys_clk = ~sys_clk;

  // Data pins: device wins while enabled, otherwise the host value
  assign hostDataIn = (hostDataOe_n === 1'b0) ? hostDataOut : busDrv;

  lcdcd_lcd_timer lcdcd_lcd_timer_inst (
    .line_transfer_clock(line_transfer_clock),
    .first_line_marker  (first_line_marker)
  );

  lcdcd_column_driver lcdcd_column_driver_inst (
    .sys_clk(sys_clk), .reset(reset), .line_transfer_clock(line_transfer_clock),
    .first_line_marker(first_line_marker), .acPolarity(acPolarity),
    .display_blank_n(display_blank_n), .output_order_reverse(output_order_reverse),
    .id_strap_bit0(MY_ID[0]), .id_strap_bit1(MY_ID[1]), .testMode(testMode),
    .chipSelect_n(chipSelect_n), .writeStrobe_n(writeStrobe_n),
    .readStrobe_n(readStrobe_n), .host_address(host_address), .hostDataIn(hostDataIn),
    .hostDataOut(hostDataOut), .hostDataOe_n(hostDataOe_n), .drawBusy(drawBusy),
    .column_drive_outputs(column_drive_outputs), .frameRateGrayPhase(frameRateGrayPhase)
  );

  // Host address: identity on top, then line, then byte
  function automatic logic [15:0] addrOf(input logic [1:0] id, input int ln, input int by);
    return {id, 7'(ln), 7'(by)};
  endfunction

  // Pixels limited to full on or full off so gray phase cannot matter
  function automatic logic [7:0] spread(input logic [3:0] x);
    return {{2{x[3]}}, {2{x[2]}}, {2{x[1]}}, {2{x[0]}}};
  endfunction

  // Expected drive codes of one line: on picks select, polarity picks high or low
  function automatic logic [2*COLUMNS-1:0] expCols(input int ln, input logic pol,
                                                   input logic rev);
    int         d;
    logic [1:0] px;
    expCols = '0;
    for (int c = 0; c < COLUMNS; c++) begin
      d = rev ? COLUMNS - 1 - c : c;
      px = shadow[ln * BYTES_LINE + d / 4][2 * (d % 4) +: 2];
      expCols[2 * c +: 2] = {~px[1], pol};
    end
  endfunction

  // Compare and count
  task automatic chk(input string nm, input logic [2*COLUMNS-1:0] exp,
                     input logic [2*COLUMNS-1:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One SRAM-style cycle, held until answered or a bound runs out
  task automatic hacc(input logic wr, input logic cs, input logic [15:0] a,
                      input logic [7:0] d, output logic [7:0] q, output logic got);
    @(negedge sys_clk);
    host_address = a;
    busDrv = d;
    chipSelect_n = ~cs;
    writeStrobe_n = ~wr;
    readStrobe_n = wr;
    got = 1'b0;
    q = 8'h00;
    // Reads may wait out a whole line refresh, which has priority
    for (int i = 0; i < (wr ? 8 : 60) && !got; i++) begin
      @(negedge sys_clk);
      if (!wr && hostDataOe_n === 1'b0) begin
        got = 1'b1;
        q = hostDataOut;
      end
    end
    chipSelect_n = 1'b1;
    writeStrobe_n = 1'b1;
    readStrobe_n = 1'b1;
    busDrv = ~d;
    for (int i = 0; i < 30 && drawBusy !== 1'b0; i++) @(negedge sys_clk);
    chk("drawBusy", '0, drawBusy);
    repeat (4) @(negedge sys_clk);
  endtask

  task automatic wrB(input int ln, input int by, input logic [7:0] d);
    logic [7:0] q;
    logic       g;
    hacc(1'b1, 1'b1, addrOf(MY_ID, ln, by), d, q, g);
    shadow[ln * BYTES_LINE + by] = d;
  endtask

  task automatic rdB(input int ln, input int by);
    logic [7:0] q;
    logic       g;
    hacc(1'b0, 1'b1, addrOf(MY_ID, ln, by), 8'h00, q, g);
    chk("readAnswered", 1'b1, g);
    chk("readData", shadow[ln * BYTES_LINE + by], q);
  endtask

  // One line transfer, then the latched line is compared
  task automatic refresh(input logic mk, input int ln);
    logic [FRC_W-1:0] ph;
    ph = frameRateGrayPhase;
    lcdcd_lcd_timer_inst.line_pulse(mk);
    repeat (30) @(negedge sys_clk);
    chk("columns", expCols(ln, acPolarity, output_order_reverse),
        column_drive_outputs);
    if (mk) chk("grayPhase", FRC_W'(ph + 1'b1), frameRateGrayPhase);
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (100000) @(posedge sys_clk);
    n_errors++;
    $display("BAD watchdog expected finish seen hang");
    tally_and_finish();
  end

  initial begin
    logic [7:0]  q;
    logic        g;
    logic [15:0] badA [4];
    int          ln;
    int          bt;
    void'($urandom(32'h38AA09BB));
    repeat (12) @(negedge sys_clk);
    reset = 1'b0;
    repeat (4) @(negedge sys_clk);
    // Empty latch with polarity low: every column sits at deselect high
    chk("colsReset", {COLUMNS{LEVEL_V3}}, column_drive_outputs);
    chk("oeReset", 1'b1, hostDataOe_n);
    // A few transfers before the first checked one
    repeat (3) lcdcd_lcd_timer_inst.line_pulse(1'b1);
    // Random write then read back of the same byte, top corner first
    for (int i = 0; i < 40; i++) begin
      ln = (i == 0) ? 119 : int'($urandom_range(119));
      bt = (i == 0) ? 39 : int'($urandom_range(39));
      wrB(ln, bt, 8'($urandom));
      rdB(ln, bt);
    end
    // Fill the first two lines for refresh
    for (int k = 0; k < 2 * BYTES_LINE; k++)
      wrB(k / BYTES_LINE, k % BYTES_LINE, spread(4'($urandom)));
    // Every order and polarity over a marker line and the next one
    for (int m = 0; m < 4; m++) begin
      @(negedge sys_clk);
      output_order_reverse = m[1];
      acPolarity = m[0];
      refresh(1'b1, 0);
      refresh(1'b0, 1);
    end
    // Host read racing a refresh still completes
    fork
      lcdcd_lcd_timer_inst.line_pulse(1'b1);
      begin
        #800;
        rdB(1, 5);
      end
    join
    repeat (30) @(negedge sys_clk);
    chk("colsAfterRace", expCols(0, acPolarity, output_order_reverse),
        column_drive_outputs);
    // Blanking forces all columns to select high, then drive returns
    display_blank_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("blanked", '0, column_drive_outputs);
    display_blank_n = 1'b1;
    acPolarity = ~acPolarity;
    repeat (3) @(negedge sys_clk);
    chk("unblanked", expCols(0, acPolarity, output_order_reverse),
        column_drive_outputs);
    // Accesses outside the window or while deselected are ignored
    badA = '{addrOf(MY_ID, 0, 0), addrOf(MY_ID ^ 2'h1, 0, 0),
             {MY_ID, 7'h78, 7'h00}, {MY_ID, 7'h00, 7'h28}};
    foreach (badA[k]) hacc(1'b1, k != 0, badA[k], 8'h5A, q, g);
    rdB(0, 0);
    rdB(1, 0);
    hacc(1'b0, 1'b1, addrOf(MY_ID ^ 2'h3, 0, 0), 8'h00, q, g);
    chk("foreignRead", 1'b0, g);
    hacc(1'b0, 1'b0, addrOf(MY_ID, 0, 0), 8'h00, q, g);
    chk("standbyRead", 1'b0, g);
    tally_and_finish();
  end
endmodule
